// >>> inc/hcd_pkg.sv
package hcd_pkg;

  // Command codes
  localparam logic [7:0]  IDENTITY_READ_CMD   = 8'h80;
  localparam logic [7:0]  CONFIG_WRITE_CMD    = 8'h81;
  localparam logic [7:0]  INT_CODE_READ_CMD   = 8'h82;
  localparam logic [7:0]  SOFT_RESET_CMD      = 8'h83;
  localparam logic [7:0]  PULL_DIR_WRITE_CMD  = 8'h84;
  localparam logic [7:0]  DIRECTION_WRITE_CMD = 8'h85;
  localparam logic [7:0]  RESET_KEY           = 8'hAA;

  // Reset values
  localparam logic [7:0]  CFG_RESET           = 8'h80;
  localparam logic [15:0] GPIO_PULL_RESET     = 16'h0000;
  localparam logic [15:0] GPIO_DIR_RESET      = 16'h0000;
  localparam logic [7:0]  STICKY_MASK         = 8'hEB;
  localparam logic [15:0] GPIO_LOCKED_MASK    = 16'h0200;
  localparam logic [7:0]  ZERO_BYTE           = 8'h00;

  // Data byte positions within one command
  localparam logic [1:0]  IDX_FIRST           = 2'h0;
  localparam logic [1:0]  IDX_SECOND          = 2'h1;
  localparam logic [1:0]  IDX_MAX             = 2'h3;
  localparam logic [3:0]  BITS_PER_BYTE       = 4'h8;
  localparam logic [3:0]  FIRST_TX_BIT        = 4'h1;

  // Timing
  localparam int          CLK_HZ              = 125_000_000;
  localparam int          RESET_HOLD_MS       = 60;
  localparam int          RESET_HOLD_CYCLES   = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int          HOLD_W              = 23;

  typedef struct packed {
    logic       request_pin_drive_type;
    logic       rotary_interface_enable;
    logic [1:0] spare;
    logic       second_mux_enable;
    logic       second_mux_source;
    logic       first_mux_enable;
    logic       first_mux_source;
  } hcd_cfg_t;

  typedef struct packed {
    logic [2:0] script_done;
    logic       awaiting_initialization;
    logic       error_flag;
    logic       always_zero;
    logic       encoder_change_flag;
    logic       key_event_flag;
  } hcd_int_code_t;

  typedef struct packed {
    logic       is_read;
    logic [7:0] cmd;
    logic [1:0] idx;
    logic [7:0] data;
  } hcd_evt_t;

  localparam int          EVT_W               = $bits(hcd_evt_t);

  typedef enum logic [6:0] {
    LS_IDLE     = 7'h01,
    LS_ADDR     = 7'h02,
    LS_ADDR_ACK = 7'h04,
    LS_RX       = 7'h08,
    LS_RX_ACK   = 7'h10,
    LS_TX       = 7'h20,
    LS_TX_ACK   = 7'h40
  } hcd_link_state_t;

endpackage

// >>> logic/hcd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> logic/hcd_top.sv
// Behaviour
// - Command 0x80 then two read bytes: maker code first, revision second.
// - Command 0x81 with one data byte loads the configuration register.
// - Configuration register holds 0x80 after reset.
// - Config bit 7 picks request pin drive: 0 open-drain, 1 push-pull.
// - Config bit 6 enables rotary interface and its keypad row pin function.
// - Config bit 3 enables second mux output, overriding that pin.
// - Config bit 2 picks second mux source: 0 input a, 1 input b.
// - Config bit 1 enables first mux output, overriding that pin.
// - Config bit 0 picks first mux source: 0 input a, 1 input b.
// - Command 0x82 returns interrupt code; reading clears it and releases request.
// - While awaiting initialization, reads clear nothing until a configuration write.
// - Code bits 7, 6, 5 flag script end on channels 2, 1, 0.
// - Code bit 4 shows awaiting initialization; clear in normal operation.
// - Code bit 3 flags an error; bit 2 always reads zero.
// - Code bit 1 flags a change on the encoder inputs.
// - Code bit 0 flags a key press or release event.
// - Command 0x83 with byte 0xAA performs a full reset.
// - Reset command with any other byte resets nothing and flags an error.
// - Command 0x84 two bytes, ports 15..8 then 7..0: 0 pullup, 1 pulldown.
// - Command 0x85 two bytes, ports 15..8 then 7..0: 0 input, 1 output.
// - GPIO port 9 always stays an input whatever the direction write says.
`timescale 1ns/1ps
`default_nettype none
module hcd_top #(
  parameter logic [6:0] SLAVE_ADDR        = 7'h2A,
  parameter logic [7:0] MAKER_CODE        = 8'h5A, // Arbitrary value
  parameter logic [7:0] REVISION_LEVEL    = 8'h01, // Arbitrary value
  parameter int         RESET_HOLD_CYCLES = hcd_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [2:0]  script_done_i,
  input  wire logic        error_event_i,
  input  wire logic        key_event_i,
  input  wire logic [1:0]  encoder_inputs_i,
  input  wire logic        first_mux_input_a_i,
  input  wire logic        first_mux_input_b_i,
  input  wire logic        second_mux_input_a_i,
  input  wire logic        second_mux_input_b_i,
  output logic             first_mux_output_o,
  output logic             first_mux_output_oe_o,
  output logic             second_mux_output_o,
  output logic             second_mux_output_oe_o,
  output logic             rotary_interface_enable_o,
  output logic [15:0]      gpio_pull_select_o,
  output logic [15:0]      gpio_direction_o,
  output logic             irq_o,
  output logic             irq_oe_o
);

  // ---------------- Link domain: byte engine ----------------

  logic [1:0]                  pins_q;
  logic                        scl_q;
  logic                        sda_q;
  logic                        scl_d;
  logic                        sda_d;
  logic                        bus_start;
  logic                        bus_stop;
  logic                        scl_rise;
  logic                        scl_fall;
  hcd_pkg::hcd_link_state_t    state;
  logic [3:0]                  bit_cnt;
  logic [7:0]                  shreg;
  logic [7:0]                  tx_byte;
  logic [7:0]                  tx_next;
  logic                        is_read_xfer;
  logic [7:0]                  cmd;
  logic                        cmd_valid;
  logic [1:0]                  data_idx;
  logic                        master_ack;
  logic                        evt_send;
  hcd_pkg::hcd_evt_t           evt_word;
  hcd_pkg::hcd_int_code_t      code_snap;
  logic                        snap_valid;
  hcd_pkg::hcd_int_code_t      snap_word;

  hcd_sync #(
    .W (2)
  ) u_link_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     (pins_q)
  );

  assign scl_q     = pins_q[1];
  assign sda_q     = pins_q[0];
  assign bus_start = scl_q && scl_d && sda_d && !sda_q;
  assign bus_stop  = scl_q && scl_d && !sda_d && sda_q;
  assign scl_rise  = scl_q && !scl_d;
  assign scl_fall  = !scl_q && scl_d;

  // Byte the host reads for a command and position
  function automatic logic [7:0] tx_pick(input logic [7:0] c, input logic [1:0] i,
                                         input logic [7:0] snap);
    logic [7:0] b;
    b = hcd_pkg::ZERO_BYTE;
    if (c == hcd_pkg::IDENTITY_READ_CMD) begin
      if (i == hcd_pkg::IDX_FIRST) begin
        b = MAKER_CODE;
      end else if (i == hcd_pkg::IDX_SECOND) begin
        b = REVISION_LEVEL;
      end
    end else if (c == hcd_pkg::INT_CODE_READ_CMD && i == hcd_pkg::IDX_FIRST) begin
      b = snap;
    end
    return b;
  endfunction

  assign tx_next = tx_pick(cmd, data_idx, code_snap);

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_snap <= '0;
    end else if (snap_valid) begin
      code_snap <= snap_word;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= hcd_pkg::LS_IDLE;
      bit_cnt      <= 4'h0;
      shreg        <= 8'h00;
      tx_byte      <= 8'h00;
      is_read_xfer <= 1'b0;
      cmd          <= 8'h00;
      cmd_valid    <= 1'b0;
      data_idx     <= hcd_pkg::IDX_FIRST;
      master_ack   <= 1'b0;
      sda_oe_o     <= 1'b0;
      evt_send     <= 1'b0;
      evt_word     <= '0;
    end else begin
      evt_send <= 1'b0;
      if (bus_stop) begin
        // Command ends with its transaction
        state     <= hcd_pkg::LS_IDLE;
        sda_oe_o  <= 1'b0;
        cmd_valid <= 1'b0;
      end else if (bus_start) begin
        // Repeated start keeps the command, data count restarts
        state    <= hcd_pkg::LS_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
        data_idx <= hcd_pkg::IDX_FIRST;
      end else begin
        unique case (state)
          hcd_pkg::LS_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          hcd_pkg::LS_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_q};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == hcd_pkg::BITS_PER_BYTE) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                sda_oe_o     <= 1'b1;
                is_read_xfer <= shreg[0];
                state        <= hcd_pkg::LS_ADDR_ACK;
              end else begin
                state <= hcd_pkg::LS_IDLE;
              end
            end
          end
          hcd_pkg::LS_ADDR_ACK: begin
            if (scl_fall) begin
              if (is_read_xfer) begin
                tx_byte  <= tx_next;
                shreg    <= tx_next;
                sda_oe_o <= !tx_next[7];
                bit_cnt  <= hcd_pkg::FIRST_TX_BIT;
                state    <= hcd_pkg::LS_TX;
              end else begin
                sda_oe_o <= 1'b0;
                bit_cnt  <= 4'h0;
                state    <= hcd_pkg::LS_RX;
              end
            end
          end
          hcd_pkg::LS_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_q};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == hcd_pkg::BITS_PER_BYTE) begin
              sda_oe_o <= 1'b1;
              state    <= hcd_pkg::LS_RX_ACK;
              if (!cmd_valid) begin
                cmd       <= shreg;
                cmd_valid <= 1'b1;
              end else begin
                evt_send         <= 1'b1;
                evt_word.is_read <= 1'b0;
                evt_word.cmd     <= cmd;
                evt_word.idx     <= data_idx;
                evt_word.data    <= shreg;
                if (data_idx != hcd_pkg::IDX_MAX) begin
                  data_idx <= data_idx + 2'h1;
                end
              end
            end
          end
          hcd_pkg::LS_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              bit_cnt  <= 4'h0;
              state    <= hcd_pkg::LS_RX;
            end
          end
          hcd_pkg::LS_TX: begin
            if (scl_fall) begin
              if (bit_cnt == hcd_pkg::BITS_PER_BYTE) begin
                sda_oe_o <= 1'b0;
                state    <= hcd_pkg::LS_TX_ACK;
              end else begin
                sda_oe_o <= !shreg[6];
                shreg    <= {shreg[6:0], 1'b0};
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          hcd_pkg::LS_TX_ACK: begin
            if (scl_rise) begin
              master_ack <= !sda_q;
              if (cmd_valid) begin
                // Carries the byte really sent, so only those bits are cleared
                evt_send         <= 1'b1;
                evt_word.is_read <= 1'b1;
                evt_word.cmd     <= cmd;
                evt_word.idx     <= data_idx;
                evt_word.data    <= tx_byte;
              end
              if (data_idx != hcd_pkg::IDX_MAX) begin
                data_idx <= data_idx + 2'h1;
              end
            end else if (scl_fall) begin
              if (master_ack) begin
                tx_byte  <= tx_next;
                shreg    <= tx_next;
                sda_oe_o <= !tx_next[7];
                bit_cnt  <= hcd_pkg::FIRST_TX_BIT;
                state    <= hcd_pkg::LS_TX;
              end else begin
                state <= hcd_pkg::LS_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;

  // ---------------- Crossings ----------------

  logic                   evt_valid;
  hcd_pkg::hcd_evt_t      evt;
  hcd_pkg::hcd_int_code_t int_code;

  hcd_xing #(
    .W (hcd_pkg::EVT_W)
  ) u_evt_xing (
    .src_clk_i (link_clk_i),
    .dst_clk_i (clk_i),
    .rst_b_i   (rst_b_i),
    .send_i    (evt_send),
    .data_i    (evt_word),
    .ready_o   (),
    .valid_o   (evt_valid),
    .data_o    (evt)
  );

  // Code is streamed continuously; the link always holds a recent copy
  hcd_xing #(
    .W (8)
  ) u_code_xing (
    .src_clk_i (clk_i),
    .dst_clk_i (link_clk_i),
    .rst_b_i   (rst_b_i),
    .send_i    (1'b1),
    .data_i    (int_code),
    .ready_o   (),
    .valid_o   (snap_valid),
    .data_o    (snap_word)
  );

  // ---------------- System domain: command decode ----------------

  logic [5:0]          sys_pins_q;
  logic [1:0]          enc_d;
  hcd_pkg::hcd_cfg_t   cfg;
  logic                awaiting;
  logic [7:0]          sticky;
  logic [7:0]          deferred_clr;
  logic [7:0]          next_sticky;
  logic [7:0]          set_vec;
  logic [7:0]          clr_vec;
  logic [7:0]          stage_hi;
  logic                soft_rst;
  logic [hcd_pkg::HOLD_W-1:0] hold_cnt;
  logic                hold_active;
  logic                wr_evt;
  logic                cfg_wr;
  logic                rst_cmd;
  logic                bad_key;
  logic                code_rd;
  logic                enc_change;
  logic                irq_level_low;

  hcd_sync #(
    .W (6)
  ) u_sys_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({encoder_inputs_i, second_mux_input_b_i, second_mux_input_a_i,
               first_mux_input_b_i, first_mux_input_a_i}),
    .q_o     (sys_pins_q)
  );

  assign wr_evt  = evt_valid && !evt.is_read;
  assign cfg_wr  = wr_evt && evt.cmd == hcd_pkg::CONFIG_WRITE_CMD && evt.idx == hcd_pkg::IDX_FIRST;
  assign rst_cmd = wr_evt && evt.cmd == hcd_pkg::SOFT_RESET_CMD && evt.idx == hcd_pkg::IDX_FIRST;
  assign bad_key = rst_cmd && evt.data != hcd_pkg::RESET_KEY;
  assign code_rd = evt_valid && evt.is_read && evt.cmd == hcd_pkg::INT_CODE_READ_CMD
                   && evt.idx == hcd_pkg::IDX_FIRST;
  assign enc_change = cfg.rotary_interface_enable && (sys_pins_q[5:4] != enc_d);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      soft_rst <= 1'b0;
      enc_d    <= 2'h0;
    end else begin
      soft_rst <= rst_cmd && evt.data == hcd_pkg::RESET_KEY;
      enc_d    <= sys_pins_q[5:4];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= hcd_pkg::CFG_RESET;
    end else if (soft_rst) begin
      cfg <= hcd_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= evt.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awaiting <= 1'b1;
    end else if (soft_rst) begin
      awaiting <= 1'b1;
    end else if (cfg_wr) begin
      awaiting <= 1'b0;
    end
  end

  // Two-byte GPIO words: high byte staged, committed with the low byte
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage_hi           <= 8'h00;
      gpio_pull_select_o <= hcd_pkg::GPIO_PULL_RESET;
      gpio_direction_o   <= hcd_pkg::GPIO_DIR_RESET;
    end else if (soft_rst) begin
      gpio_pull_select_o <= hcd_pkg::GPIO_PULL_RESET;
      gpio_direction_o   <= hcd_pkg::GPIO_DIR_RESET;
    end else if (wr_evt) begin
      if (evt.idx == hcd_pkg::IDX_FIRST) begin
        stage_hi <= evt.data;
      end else if (evt.idx == hcd_pkg::IDX_SECOND) begin
        if (evt.cmd == hcd_pkg::PULL_DIR_WRITE_CMD) begin
          gpio_pull_select_o <= {stage_hi, evt.data};
        end
        if (evt.cmd == hcd_pkg::DIRECTION_WRITE_CMD) begin
          gpio_direction_o <= {stage_hi, evt.data} & ~hcd_pkg::GPIO_LOCKED_MASK;
        end
      end
    end
  end

  always_comb begin
    set_vec = {script_done_i, 1'b0, error_event_i || bad_key, 1'b0, enc_change,
               key_event_i};
    clr_vec = 8'h00;
    if (code_rd && !awaiting) begin
      clr_vec = evt.data;
    end
    if (cfg_wr) begin
      clr_vec = clr_vec | deferred_clr;
    end
    // Set wins over clear
    next_sticky = (set_vec | (sticky & ~clr_vec)) & hcd_pkg::STICKY_MASK;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sticky       <= 8'h00;
      deferred_clr <= 8'h00;
    end else if (soft_rst) begin
      sticky       <= 8'h00;
      deferred_clr <= 8'h00;
    end else begin
      sticky <= next_sticky;
      if (cfg_wr) begin
        deferred_clr <= 8'h00;
      end else if (code_rd && awaiting) begin
        deferred_clr <= deferred_clr | evt.data;
      end
    end
  end

  always_comb begin
    int_code                         = sticky;
    int_code.awaiting_initialization = awaiting;
    int_code.always_zero             = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt    <= '0;
      hold_active <= 1'b0;
    end else if (soft_rst) begin
      hold_cnt    <= hcd_pkg::HOLD_W'(RESET_HOLD_CYCLES - 1);
      hold_active <= 1'b1;
    end else if (hold_active) begin
      hold_cnt <= hold_cnt - 1'b1;
      if (hold_cnt == '0) begin
        hold_active <= 1'b0;
      end
    end
  end

  // Request is active low; held released during the post-reset window
  assign irq_level_low = (|int_code) && !hold_active;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o    <= 1'b0;
      irq_oe_o <= 1'b0;
    end else if (cfg.request_pin_drive_type) begin
      irq_o    <= !irq_level_low;
      irq_oe_o <= 1'b1;
    end else begin
      irq_o    <= 1'b0;
      irq_oe_o <= irq_level_low;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_mux_output_o     <= 1'b0;
      first_mux_output_oe_o  <= 1'b0;
      second_mux_output_o    <= 1'b0;
      second_mux_output_oe_o <= 1'b0;
    end else begin
      first_mux_output_oe_o  <= cfg.first_mux_enable;
      first_mux_output_o     <= cfg.first_mux_enable &&
                                (cfg.first_mux_source ? sys_pins_q[1] : sys_pins_q[0]);
      second_mux_output_oe_o <= cfg.second_mux_enable;
      second_mux_output_o    <= cfg.second_mux_enable &&
                                (cfg.second_mux_source ? sys_pins_q[3] : sys_pins_q[2]);
    end
  end

  assign rotary_interface_enable_o = cfg.rotary_interface_enable;

endmodule
`default_nettype wire

// >>> logic/hcd_xing.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_xing #(
  parameter int W = 8
) (
  input  wire logic         src_clk_i,
  input  wire logic         dst_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         send_i,
  input  wire logic [W-1:0] data_i,
  output logic              ready_o,
  output logic              valid_o,
  output logic      [W-1:0] data_o
);
  logic         req;
  logic [W-1:0] hold;
  logic [1:0]   ack_s;
  logic [2:0]   req_s;

  // Hold stays put until the toggle comes back, so dst may sample it
  assign ready_o = (req == ack_s[1]);

  always_ff @(posedge src_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (send_i && ready_o) begin
      req  <= ~req;
      hold <= data_i;
    end
  end

  always_ff @(posedge src_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_s <= 2'h0;
    end else begin
      ack_s <= {ack_s[0], req_s[2]};
    end
  end

  always_ff @(posedge dst_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_s   <= 3'h0;
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      req_s   <= {req_s[1:0], req};
      valid_o <= req_s[2] ^ req_s[1];
      if (req_s[2] ^ req_s[1]) begin
        data_o <= hold;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/hcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_host #(
  parameter logic [6:0] ADR = 7'h2A
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o = 1'b1,
  output logic      sda_low_o = 1'b0,
  output logic      nak_o = 1'b0
);
  // Phases of 32 and 48 cycles keep the link sampler's setup and hold
  task h(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task bt(input logic b, output logic r);
    h(32);
    sda_low_o = !b;
    h(32);
    scl_o = 1'b1;
    h(48);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task byt(input logic [7:0] b, input logic m, input logic c, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bt(b[i], r[i]);
    bt(m, a);
    if (c && a) nak_o = 1'b1;
  endtask
  task st;
    h(32);
    sda_low_o = 1'b0;
    h(32);
    scl_o = 1'b1;
    h(48);
    sda_low_o = 1'b1;
    h(32);
    scl_o = 1'b0;
  endtask
  task sp;
    h(32);
    sda_low_o = 1'b1;
    h(32);
    scl_o = 1'b1;
    h(48);
    sda_low_o = 1'b0;
    h(48);
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d, input int n);
    logic [7:0] r;
    st;
    byt({ADR, 1'b0}, 1'b1, 1'b1, r);
    byt(c, 1'b1, 1'b1, r);
    if (n > 1) byt(d[15:8], 1'b1, 1'b1, r);
    if (n > 0) byt(d[7:0], 1'b1, 1'b1, r);
    if (n >= 0) sp;
  endtask
  task rd(input logic [7:0] c, input int n, output logic [15:0] q);
    logic [7:0] r;
    q = 16'h0000;
    wr(c, 16'h0000, -1);
    st;
    byt({ADR, 1'b1}, 1'b1, 1'b1, r);
    for (int i = 1; i <= n; i++) begin
      byt(8'hFF, i == n, 1'b0, r);
      q = {q[7:0], r};
    end
    sp;
  endtask
endmodule
`default_nettype wire

// >>> test/hcd_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_top_monitor (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        first_mux_input_a_i,
  input wire logic        first_mux_input_b_i,
  input wire logic        second_mux_input_a_i,
  input wire logic        second_mux_input_b_i,
  input wire logic        first_mux_output_o,
  input wire logic        first_mux_output_oe_o,
  input wire logic        second_mux_output_o,
  input wire logic        second_mux_output_oe_o,
  input wire logic        rotary_interface_enable_o,
  input wire logic [15:0] gpio_direction_o,
  input wire logic        irq_o,
  input wire logic        irq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_g9; gpio_direction_o[9] == 1'b0; endproperty
  a_g9: assert property (p_g9) else $error("port 9 became an output");
  property p_od; !irq_oe_o |-> !irq_o; endproperty
  a_od: assert property (p_od) else $error("request level set while undriven");
  property p_m1z; !first_mux_output_oe_o |-> !first_mux_output_o; endproperty
  a_m1z: assert property (p_m1z) else $error("first mux output while disabled");
  property p_m2z; !second_mux_output_oe_o |-> !second_mux_output_o; endproperty
  a_m2z: assert property (p_m2z) else $error("second mux output while disabled");
  // Equal steady inputs make the check independent of the source bit
  property p_m1s; (first_mux_output_oe_o && first_mux_input_a_i == first_mux_input_b_i
    && $stable(first_mux_input_a_i))[*5] |-> first_mux_output_o == first_mux_input_a_i; endproperty
  a_m1s: assert property (p_m1s) else $error("first mux output not its input");
  property p_m2s; (second_mux_output_oe_o && second_mux_input_a_i == second_mux_input_b_i
    && $stable(second_mux_input_a_i))[*5] |-> second_mux_output_o == second_mux_input_a_i; endproperty
  a_m2s: assert property (p_m2s) else $error("second mux output not its input");
  property p_ri; $rose(rst_b_i) |-> ##[1:4] (irq_oe_o && !irq_o); endproperty
  a_ri: assert property (p_ri) else $error("no request after reset");
  property p_rc; $rose(rst_b_i) |-> !rotary_interface_enable_o && !first_mux_output_oe_o
    && !second_mux_output_oe_o; endproperty
  a_rc: assert property (p_rc) else $error("configuration outputs wrong after reset");
  c_m1: cover property (first_mux_output_oe_o && first_mux_output_o);
  c_pp: cover property (irq_oe_o && irq_o);
  c_rot: cover property (rotary_interface_enable_o);
endmodule
bind hcd_top hcd_top_monitor mon (.*);
`default_nettype wire

// >>> test/hcd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_top_tb;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, link_clk_i = 1'b0, sda_o, sda_oe_o, sda_low, nak;
  logic        error_event_i = 1'b0, key_event_i = 1'b0, irq_o, irq_oe_o, rotary_interface_enable_o;
  logic        first_mux_input_a_i = 1'b0, first_mux_input_b_i = 1'b0, first_mux_output_o, first_mux_output_oe_o;
  logic        second_mux_input_a_i = 1'b0, second_mux_input_b_i = 1'b0, second_mux_output_o, second_mux_output_oe_o;
  logic [2:0]  script_done_i = 3'h0;
  logic [1:0]  encoder_inputs_i = 2'h0;
  logic [15:0] gpio_pull_select_o, gpio_direction_o, q;
  int          error_cnt = 0, compares = 0, k;
  wire logic   scl_i, sda_i, irq_w;
  assign sda_i = !(sda_low || sda_oe_o);
  assign irq_w = irq_oe_o ? irq_o : 1'b1;
  always #4 clk_i = ~clk_i;
  initial begin
    #3;
    forever #40 link_clk_i = ~link_clk_i;
  end
  hcd_top #(.RESET_HOLD_CYCLES(2000)) uut (.*);
  hcd_host host (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low), .nak_o(nak));
  task w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    w(6);
    rst_b_i = 1'b1;
    w(40);
    chk("irq after reset", 16'h0000, irq_w);
    host.rd(8'h80, 2, q);
    chk("identity", 16'h5A01, q);
    host.rd(8'h82, 1, q);
    chk("code init", 16'h0010, q);
    host.wr(8'h81, 16'h000F, 1);
    w(300);
    chk("irq released", 16'h0001, irq_w);
    chk("open drain", 16'h0000, irq_oe_o);
    chk("mux enables", 16'h0003, {second_mux_output_oe_o, first_mux_output_oe_o});
    first_mux_input_b_i = 1'b1;
    second_mux_input_b_i = 1'b1;
    w(10);
    chk("mux sources", 16'h0003, {second_mux_output_o, first_mux_output_o});
    host.wr(8'h81, 16'h00C0, 1);
    w(300);
    chk("cfg c0", 16'h001C, {rotary_interface_enable_o, irq_oe_o, irq_o, second_mux_output_oe_o,
      first_mux_output_oe_o});
    $display("configuration test done");
    script_done_i = 3'h7;
    error_event_i = 1'b1;
    key_event_i = 1'b1;
    encoder_inputs_i = 2'h1;
    w(1);
    script_done_i = 3'h0;
    error_event_i = 1'b0;
    key_event_i = 1'b0;
    w(300);
    chk("irq on events", 16'h0000, irq_w);
    host.rd(8'h82, 1, q);
    chk("code", 16'h00EB, q);
    chk("irq acked", 16'h0001, irq_w);
    $display("event test done");
    host.wr(8'h84, 16'hA53C, 2);
    host.wr(8'h85, 16'hFFFF, 2);
    w(300);
    chk("pull", 16'hA53C, gpio_pull_select_o);
    chk("direction", 16'hFDFF, gpio_direction_o);
    $display("gpio test done");
    host.wr(8'h83, 16'h0055, 1);
    w(300);
    chk("bad key keeps cfg", 16'h0001, rotary_interface_enable_o);
    host.rd(8'h82, 1, q);
    chk("bad key", 16'h0008, q);
    host.wr(8'h83, 16'h00AA, 1);
    w(200);
    chk("hold released", 16'h0001, irq_w);
    for (k = 0; k < 3000 && irq_w !== 1'b0; k++) w(1);
    chk("ready", 16'h0000, irq_w);
    chk("soft reset", 16'h0000, gpio_direction_o | gpio_pull_select_o | rotary_interface_enable_o);
    chk("acks", 16'h0000, nak);
    $display("reset test done");
    wrap_up;
  end
  initial begin
    w(100000);
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
